/* rtl/drac_pkg.sv */
// What this block does
// - read/write fields store host writes and return them on later reads
// - read-only fields return their value and ignore host writes
// - write-only fields act on writes but always read back zero
// - hardware-affected read/write fields: host writes and reads, logic may also update
// - hardware-affected read-only fields ignore writes, logic updates, reads show current value
// - sticky field leaves reset value and returns only through reset
// - no host write or internal logic restores a sticky field to reset value
// - reserved unimplemented fields always read zero
// - writes to reserved fields change nothing and have no side effect
// - each address selects one whole register word, no byte addressing
// - clamp configuration at word 1E, reset value 2600 hex
// - clock check register at word 1F, reset value 0001 hex
// - pin mirror register resets to 0020 hex, then follows the synchronised pin levels
// - register space spans word addresses 00 to 1F
package drac_pkg;
    // ====================================================
    // register map
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam logic [4:0] ADDR_LAST = 5'h1f;
    localparam logic [4:0] OFS_PIN_STATUS = 5'h0a;
    localparam logic [4:0] OFS_CLAMP_CFG = 5'h1e;
    localparam logic [4:0] OFS_CLK_CHECK = 5'h1f;
    localparam logic [15:0] RST_CLAMP_CFG = 16'h2600;
    localparam logic [15:0] RST_CLK_CHECK = 16'h0001;
    localparam logic [15:0] RST_PIN_STATUS = 16'h0020;
    // ====================================================
    // field layouts (chosen)
    localparam logic [15:0] CLAMP_RW_MASK = 16'hff00; // rw field bits
    localparam logic [15:0] CLAMP_WO_MASK = 16'h0001; // write-only pulse bit
    localparam logic [15:0] CLAMP_RWH_MASK = 16'h00f0; // rw, hardware may set
    localparam int CS2_LSB = 4;       // sticky counter value [15:4]
    localparam int CS2_W = 12;
    localparam logic [15:0] PIN_MASK = 16'h003f; // six mirrored pins
endpackage : drac_pkg

/* rtl/drac_regif.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// register access carrier between core and word decoder
interface drac_regif;
    logic wrEn;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    modport core (input wrEn, input addr, input wdata, output rdata);
    modport dec (output wrEn, output addr, output wdata, input rdata);
endinterface : drac_regif
`default_nettype wire

/* rtl/drac_word_port.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// word port: one address selects one full 16-bit word
module drac_word_port (
    input wire logic clk,            // system clock
    input wire logic resetn,         // async reset, active low
    input wire logic accValid,       // access strobe
    input wire logic accWrite,       // 1 write, 0 read
    input wire logic [4:0] accAddr,  // word address
    input wire logic [15:0] accWdata, // write word
    output logic [15:0] accRdata,    // read word, registered
    drac_regif.dec bus               // to register core
);
    import drac_pkg::*;
    logic [15:0] rdata_ff;
    // whole-word select, no byte lanes exist
    assign bus.wrEn = accValid & accWrite;
    assign bus.addr = accAddr;
    assign bus.wdata = accWdata;
    assign accRdata = rdata_ff;
    // read data captured on the strobe edge, seen one cycle later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 16'h0000;
        end else if (accValid && !accWrite) begin
            rdata_ff <= bus.rdata;
        end
    end
endmodule : drac_word_port
`default_nettype wire

/* rtl/drac_reg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// register bank: clamp config, clock check, pin mirror
module drac_reg_bank (
    input wire logic clk,              // 200 MHz clock
    input wire logic resetn,           // async reset, active low
    input wire logic accValid,         // access strobe
    input wire logic accWrite,         // 1 write, 0 read
    input wire logic [4:0] accAddr,    // word address 00..1f
    input wire logic [15:0] accWdata,  // write word
    output logic [15:0] accRdata,      // read word, one cycle later
    input wire logic [5:0] pinLevel,   // asynchronous pin levels
    input wire logic [3:0] hwClampSet, // hardware sets clamp rwh bits
    input wire logic cntStop,          // counter transfer strobe, same clock
    input wire logic [11:0] cntValue,  // counter value to transfer
    output logic [7:0] clampCfg,       // clamp rw field
    output logic [3:0] clampHw,        // clamp rwh field
    output logic clampKick             // write-only action pulse
);
    import drac_pkg::*;
    drac_regif bus ();
    // clamp and pin registers are held as whole 16-bit words, clock check keeps only its 12-bit field
    logic [15:0] clamp_ff, nxt_clamp;
    logic [CS2_W-1:0] cs2_ff, nxt_cs2;
    logic [15:0] pin_ff;
    logic [5:0] pinMeta_ff, pinSync_ff;
    logic pinCaught_ff;
    logic pinFill_ff;
    logic kick_ff;
    logic selClamp, selClk, selPin;
    logic [15:0] wClamp;

    // hardware set bits are ORed into the rwh field on every path into the
    // register, so a host write can never hide a pending hardware event
    function automatic logic [15:0] hwMerge(input logic [15:0] base, input logic [3:0] set);
        return base | {8'h00, set, 4'h0};
    endfunction : hwMerge

    drac_word_port u_port (
        .clk(clk),
        .resetn(resetn),
        .accValid(accValid),
        .accWrite(accWrite),
        .accAddr(accAddr),
        .accWdata(accWdata),
        .accRdata(accRdata),
        .bus(bus)
    );

    // ====================================================
    // decode
    assign selClamp = bus.addr == OFS_CLAMP_CFG;
    assign selClk = bus.addr == OFS_CLK_CHECK;
    assign selPin = bus.addr == OFS_PIN_STATUS;
    // only rw and rwh bits take the write; reserved bits drop it
    assign wClamp = bus.wdata & (CLAMP_RW_MASK | CLAMP_RWH_MASK);
    // hardware set wins over host write on rwh bits
    assign nxt_clamp = (bus.wrEn && selClamp)
        ? hwMerge(wClamp, hwClampSet)
        : hwMerge(clamp_ff, hwClampSet);
    // sticky: loads cntValue on cntStop, never back to zero except by reset; host write ignored
    assign nxt_cs2 = cntStop ? cntValue : cs2_ff;
    // read mux: write-only and reserved bits read zero
    assign bus.rdata = selClamp ? (clamp_ff & ~CLAMP_WO_MASK)
        : selClk ? {cs2_ff, 4'h1}
        : selPin ? (pin_ff & PIN_MASK)
        : 16'h0000;

    assign clampCfg = clamp_ff[15:8];
    assign clampHw = clamp_ff[7:4];
    assign clampKick = kick_ff;

    // clamp configuration register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clamp_ff <= RST_CLAMP_CFG;
            kick_ff <= 1'b0;
        end else begin
            clamp_ff <= nxt_clamp;
            kick_ff <= bus.wrEn & selClamp & bus.wdata[0];
        end
    end

    // clock check sticky counter field; bit 0 fixed to reset value
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs2_ff <= RST_CLK_CHECK[15:4];
        end else if (cs2_ff == RST_CLK_CHECK[15:4] || cntValue != RST_CLK_CHECK[15:4]) begin
            cs2_ff <= nxt_cs2;
        end
    end

    // pin mirror: two-flop synchroniser on the raw pins; the reset image stands
    // until the second stage holds a real sample, so the empty synchroniser
    // never shows up as a false all-zero pin word after release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pinMeta_ff <= 6'h00;
            pinSync_ff <= 6'h00;
            pin_ff <= RST_PIN_STATUS;
            pinCaught_ff <= 1'b0;
            pinFill_ff <= 1'b0;
        end else begin
            pinMeta_ff <= pinLevel;
            pinSync_ff <= pinMeta_ff;
            pinCaught_ff <= 1'b1;
            pinFill_ff <= pinCaught_ff;
            if (pinFill_ff) begin
                pin_ff <= {10'h000, pinSync_ff};
            end
        end
    end

    // ====================================================
    // checks
    // reset images, checked on the first edge after release
    clamp_rst_a: assert property (
        @(posedge clk) $rose(resetn) |-> clamp_ff == RST_CLAMP_CFG)
        else $error("clamp reset value wrong");
    clk_rst_a: assert property (
        @(posedge clk) $rose(resetn) |-> {cs2_ff, 4'h1} == RST_CLK_CHECK)
        else $error("clock check reset value wrong");
    // host side of the clamp and clock check words
    rw_store_a: assert property (
        @(posedge clk) disable iff (!resetn)
        bus.wrEn && selClamp |=> clamp_ff[15:8] == $past(bus.wdata[15:8]))
        else $error("rw field not stored");
    clamp_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !(bus.wrEn && selClamp) && hwClampSet == 4'h0 |=> clamp_ff == $past(clamp_ff))
        else $error("clamp word changed without cause");
    ro_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        bus.wrEn && selClk && !cntStop |=> cs2_ff == $past(cs2_ff))
        else $error("read-only field took a write");
    wo_zero_a: assert property (
        @(posedge clk) disable iff (!resetn)
        selClamp |-> bus.rdata[0] == 1'b0)
        else $error("write-only bit read nonzero");
    // the action pulse follows every write that asks for it, and never a cycle without a clamp write
    kick_pulse_a: assert property (
        @(posedge clk) disable iff (!resetn)
        bus.wrEn && selClamp && bus.wdata[0] |=> clampKick)
        else $error("write-only action lost");
    kick_only_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !(bus.wrEn && selClamp) |=> !clampKick)
        else $error("spurious write-only action");
    hw_set_a: assert property (
        @(posedge clk) disable iff (!resetn)
        hwClampSet != 4'h0 |=> (clamp_ff[7:4] & $past(hwClampSet)) == $past(hwClampSet))
        else $error("hardware set lost");
    // hardware value lands in the read-only field and reads back current
    cs_load_a: assert property (
        @(posedge clk) disable iff (!resetn)
        cntStop && cntValue != 12'h000 |=> cs2_ff == $past(cntValue))
        else $error("clock check value not loaded");
    cs_read_a: assert property (
        @(posedge clk) disable iff (!resetn)
        selClk |-> bus.rdata == {cs2_ff, 4'h1})
        else $error("clock check read not current");
    sticky_a: assert property (
        @(posedge clk) disable iff (!resetn)
        cs2_ff != RST_CLK_CHECK[15:4] |=> cs2_ff != RST_CLK_CHECK[15:4])
        else $error("sticky field returned to reset");
    // unmapped words inside 00..1f and reserved bits read as zero
    resv_zero_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !selClamp && !selClk && !selPin |-> bus.rdata == 16'h0000)
        else $error("reserved word read nonzero");
    clamp_resv_a: assert property (
        @(posedge clk) disable iff (!resetn)
        selClamp |-> bus.rdata[3:1] == 3'h0)
        else $error("reserved clamp bits read nonzero");
    resv_bits_a: assert property (
        @(posedge clk) disable iff (!resetn)
        bus.wrEn && selClamp |=> clamp_ff[3:0] == 4'h0)
        else $error("reserved clamp bits took a write");
    // a read takes the whole word at the taking edge and holds it after
    rd_capture_a: assert property (
        @(posedge clk) disable iff (!resetn)
        accValid && !accWrite |=> accRdata == $past(bus.rdata))
        else $error("read word not captured");
    rd_keep_a: assert property (
        @(posedge clk) disable iff (!resetn)
        !(accValid && !accWrite) |=> $stable(accRdata))
        else $error("read word changed without a read");
    // pin mirror keeps its reset image until the synchroniser is filled
    pin_img_a: assert property (
        @(posedge clk) disable iff (!resetn)
        pinCaught_ff |-> (pin_ff & ~PIN_MASK) == 16'h0000)
        else $error("pin mirror upper bits set");
    pin_hold_a: assert property (
        @(posedge clk) disable iff (!resetn)
        pinCaught_ff && !pinFill_ff |-> pin_ff == RST_PIN_STATUS)
        else $error("pin reset image lost early");
    pin_track_a: assert property (
        @(posedge clk) disable iff (!resetn)
        pinFill_ff |=> pin_ff[5:0] == $past(pinSync_ff))
        else $error("pin mirror not tracking pins");
endmodule : drac_reg_bank
`default_nettype wire

/* tb/drac_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// host model: one whole word per access, released address and data lines invert
module drac_host_model (
    input wire logic clk, // system clock
    output logic accValid, // access strobe
    output logic accWrite, // write qualifier
    output logic [4:0] accAddr, // word address
    output logic [15:0] accWdata, // write word
    input wire logic [15:0] accRdata, // read word
    input wire logic clampKick // action pulse
);
    logic kickSeen;
    initial begin
        accValid = 1'b0;
        accWrite = 1'b0;
        accAddr = 5'h00;
        accWdata = 16'h0000;
    end
    // drive at falling edge, hold across the taking edge
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                       output logic [15:0] rd);
        @(negedge clk);
        accValid = 1'b1;
        accWrite = w;
        accAddr = a;
        accWdata = d;
        @(negedge clk);
        kickSeen = clampKick;
        accValid = 1'b0;
        accAddr = ~accAddr;
        accWdata = ~accWdata;
        @(negedge clk);
        rd = accRdata;
    endtask : acc
endmodule : drac_host_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import drac_pkg::*;
    logic clk, resetn, cntStop, accValid, accWrite, clampKick;
    logic [4:0] accAddr, aw;
    logic [15:0] accWdata, accRdata, rd, wd, clampM, csM;
    logic [5:0] pinLevel;
    logic [3:0] hwClampSet, clampHw;
    logic [11:0] cntValue;
    logic [7:0] clampCfg;
    int badCount, nCompared, cyc, seed;
    drac_reg_bank dut (.clk(clk), .resetn(resetn), .accValid(accValid), .accWrite(accWrite),
        .accAddr(accAddr), .accWdata(accWdata), .accRdata(accRdata), .pinLevel(pinLevel),
        .hwClampSet(hwClampSet), .cntStop(cntStop), .cntValue(cntValue),
        .clampCfg(clampCfg), .clampHw(clampHw), .clampKick(clampKick));
    drac_host_model host (.clk(clk), .accValid(accValid), .accWrite(accWrite),
        .accAddr(accAddr), .accWdata(accWdata), .accRdata(accRdata), .clampKick(clampKick));
    // ====================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            badCount++;
            final_report();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nCompared++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
        host.acc(1'b0, a, 16'h0000, rd);
        chk(rd, exp);
    endtask : rdchk
    task automatic final_report;
        $display("compared %0d mismatches %0d", nCompared, badCount);
        if (badCount == 0 && nCompared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    // ====================================================
    // main sequence; reset is repeated mid-run to clear the sticky field
    initial begin
        seed = 32'hb45e;
        {resetn, cntStop, hwClampSet, cntValue} = '0;
        pinLevel = 6'($random(seed));
        for (int r = 0; r < 2; r++) begin
            resetn = 1'b0;
            repeat (5) @(negedge clk);
            resetn = 1'b1;
            repeat (4) @(negedge clk);
            clampM = RST_CLAMP_CFG;
            csM = RST_CLK_CHECK;
            for (int a = 0; a < 32; a++) begin
                rdchk(5'(a), a == 30 ? clampM : a == 31 ? csM :
                      a == 10 ? {10'h000, pinLevel} : 16'h0000);
            end
            for (int i = 0; i < 8; i++) begin
                wd = 16'($random(seed)) & 16'hfff1;
                pinLevel = 6'($random(seed));
                host.acc(1'b1, OFS_CLAMP_CFG, wd, rd);
                chk({15'h0, host.kickSeen}, {15'h0, wd[0]});
                clampM = {wd[15:4], 4'h0};
                aw = 5'($random(seed));
                if (aw == OFS_CLAMP_CFG) aw = OFS_CLK_CHECK;
                host.acc(1'b1, aw, 16'($random(seed)), rd);
                // hardware sets rwh bits with no host write in the same cycle; the model ORs them in
                hwClampSet = 4'($random(seed));
                clampM[7:4] = clampM[7:4] | hwClampSet;
                @(negedge clk);
                hwClampSet = 4'h0;
                cntValue = (i == 3) ? 12'h000 : 12'($random(seed));
                if (cntValue != 12'h000) csM = {cntValue, 4'h1};
                cntStop = 1'b1;
                @(negedge clk);
                cntStop = 1'b0;
                rdchk(OFS_CLAMP_CFG, clampM);
                rdchk(OFS_CLK_CHECK, csM);
                rdchk(OFS_PIN_STATUS, {10'h000, pinLevel});
                chk({4'h0, clampCfg, clampHw}, {4'h0, clampM[15:4]});
            end
        end
        final_report();
    end
endmodule : testbench
`default_nettype wire
